// >>> rtl/sarc_defs.svh
// Timing counts, field positions and reset values for the SAR control.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef SARC_DEFS_SVH
`define SARC_DEFS_SVH

`define SARC_CLK_NS 50
`define SARC_BITS 14
`define SARC_MSB 13
`define SARC_CONV_NS 250
`define SARC_CONV_CYC ((`SARC_CONV_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_ACQ_NS 100
`define SARC_ACQ_CYC ((`SARC_ACQ_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_NAP_WAKE_NS 250
`define SARC_NAP_WAKE_CYC \
	((`SARC_NAP_WAKE_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_RES_RST 14'h0000
`define SARC_ADDR_STATUS 32'h0000_0000
`define SARC_ADDR_CLEAR 32'h0000_0004
`define SARC_ADDR_ENABLE 32'h0000_0008
`define SARC_ADDR_RESULT 32'h0000_000c
`define SARC_ADDR_CTRL 32'h0000_0010
`define SARC_EV_DONE 0
`define SARC_EV_OVR 1
`define SARC_EV_UNDR 2
`define SARC_EV_IGN 3
`define SARC_NEV 4

`endif

// >>> rtl/sarc_pkg.sv
// Types shared by the SAR conversion control files.
// Assumes the defs header is compiled alongside.
package sarc_pkg;
	typedef enum logic [1:0] {SARC_IDLE, SARC_CONV, SARC_LOAD} sarc_state_t;
	typedef enum logic [1:0] {SARC_0DB, SARC_M3DB, SARC_M6DB, SARC_M9DB}
		sarc_span_t;
	typedef enum logic [1:0] {SARC_ACTIVE, SARC_NAP, SARC_SLEEP} sarc_pwr_t;
endpackage

// >>> rtl/sarc_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes inputs are asynchronous to clk.
module sarc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] rst_val,
	// Pins in, synced out
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// First stage read only by second stage
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta_q <= rst_val;
			sync_out <= rst_val;
		end
		else
		begin
			meta_q <= pin_in;
			sync_out <= meta_q;
		end
	end
endmodule

// >>> rtl/sarc_sar.sv
// Successive-approximation register: decides one bit per step, MSB first.
// Assumes comp_hi is the comparator verdict for the current trial code.
`include "sarc_defs.svh"
module sarc_sar (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Sequencing
	input wire logic start,
	input wire logic step,
	input wire logic comp_hi,
	// Trial word and completion
	output logic [`SARC_MSB:0] trial_q,
	output logic done
);
	logic [`SARC_MSB:0] mask_q;
	logic [`SARC_MSB:0] word_q;

	assign trial_q = word_q | mask_q;
	assign done = (mask_q == 14'h0000);

	// Mask walks from bit 13 down to bit 0
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			mask_q <= 14'h0000;
			word_q <= 14'h0000;
		end
		else if (start)
		begin
			mask_q <= 14'h2000;
			word_q <= 14'h0000;
		end
		else if (step && !done)
		begin
			if (comp_hi)
				word_q <= word_q | mask_q;
			mask_q <= mask_q >> 1;
		end
	end
endmodule

// >>> rtl/sarc_top.sv
// Conversion control for a 14-bit SAR converter with AXI4-Lite status.
// Assumes pins are asynchronous; analog comparator modelled by ain_code.
// Function
// - A falling edge on convert_start_n alone starts a conversion.
// - Start edges during a conversion are ignored; no restart or abort.
// - busy_n is low for the whole conversion, high otherwise. Here busy_n is forced high in nap or sleep, even while a conversion runs on.
// - SAR decides the 14 bits one at a time, MSB to LSB.
// - Finished SAR word is loaded into the output latches.
// - Result on bits 13..0, bit 13 the most significant.
// - Overrange drives out_of_range_flag high with result MSB low.
// - Range selects decode to 0dB, -3dB, -6dB or -9dB spans.
// - nap_n low powers conversion off, reference stays active.
// - deep_powerdown_n low shuts all circuitry down.
// - Result is two's complement, zero at the negative input.
// - out_of_range_flag stays low for inputs within the span.
// - Underrange drives out_of_range_flag high with result MSB high.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`include "sarc_defs.svh"

module sarc_top (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Converter pins
	input wire logic convert_start_n,
	input wire logic range_select0,
	input wire logic range_select1,
	input wire logic nap_n,
	input wire logic deep_powerdown_n,
	output logic busy_n,
	output logic [`SARC_MSB:0] result_bits,
	output logic out_of_range_flag,
	// Analog front end model: signed input code, over/under span
	input wire logic signed [15:0] ain_code,
	output logic ref_active,
	output logic [1:0] span_sel,
	// AXI4-Lite slave
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt
	output logic irq
);
	logic [4:0] pins_s;
	logic cs_s, r0_s, r1_s, nap_s, slp_s;
	logic cs_prev_q;
	logic start_edge;
	sarc_pkg::sarc_state_t state_q;
	sarc_pkg::sarc_pwr_t pwr_q;
	logic [3:0] cnt_q;
	logic sar_start, sar_step, sar_done, comp_hi;
	logic [`SARC_MSB:0] trial;
	logic signed [15:0] full_pos, full_neg, clamped;
	logic over_q, under_q;
	logic [`SARC_NEV-1:0] status_q, enable_q, events;
	logic [1:0] bresp_d;

	// Every pin passes two flops before use
	sarc_sync #(.W(5)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.rst_val(5'h1f),
		.pin_in({convert_start_n, range_select0, range_select1, nap_n,
			deep_powerdown_n}),
		.sync_out(pins_s)
	);
	assign {cs_s, r0_s, r1_s, nap_s, slp_s} = pins_s;

	// Span from range selects; one full scale per span
	function automatic sarc_pkg::sarc_span_t span_of(input logic s0,
		input logic s1);
		span_of = sarc_pkg::sarc_span_t'({~s0, ~s1});
	endfunction
	assign span_sel = span_of(r0_s, r1_s);

	// MSB flip between two's complement and offset binary
	function automatic logic [`SARC_MSB:0] flip_msb(
		input logic [`SARC_MSB:0] w);
		flip_msb = {~w[`SARC_MSB], w[`SARC_MSB-1:0]};
	endfunction

	// Power mode: sleep wins over nap
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pwr_q <= sarc_pkg::SARC_ACTIVE;
		else if (!slp_s)
			pwr_q <= sarc_pkg::SARC_SLEEP;
		else if (!nap_s)
			pwr_q <= sarc_pkg::SARC_NAP;
		else
			pwr_q <= sarc_pkg::SARC_ACTIVE;
	end
	assign ref_active = (pwr_q != sarc_pkg::SARC_SLEEP);

	// Falling edge detect after the synchroniser; reset reads as high
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cs_prev_q <= 1'b1;
		else
			cs_prev_q <= cs_s;
	end
	assign start_edge = cs_prev_q & ~cs_s;

	// Model comparator: clamp input to the 14-bit code range
	assign full_pos = 16'sh1fff;
	assign full_neg = -16'sh2000;
	assign clamped = (ain_code > full_pos) ? full_pos :
		(ain_code < full_neg) ? full_neg : ain_code;
	// SAR builds an offset-binary word, so the compare stays unsigned
	assign comp_hi = (flip_msb(clamped[13:0]) >= trial);

	// Only the pin edge starts a conversion
	assign sar_start = (state_q == sarc_pkg::SARC_IDLE) &&
		(pwr_q == sarc_pkg::SARC_ACTIVE) && start_edge;

	// Conversion sequencer; edges outside IDLE are dropped
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			state_q <= sarc_pkg::SARC_IDLE;
		else
		begin
			unique case (state_q)
				sarc_pkg::SARC_IDLE:
					if (sar_start)
						state_q <= sarc_pkg::SARC_CONV;
				sarc_pkg::SARC_CONV:
					if (sar_done)
						state_q <= sarc_pkg::SARC_LOAD;
				sarc_pkg::SARC_LOAD:
					state_q <= sarc_pkg::SARC_IDLE;
				default:
					state_q <= sarc_pkg::SARC_IDLE;
			endcase
		end
	end
	assign sar_step = (state_q == sarc_pkg::SARC_CONV);

	// Cycles in conversion, visible in the control word
	always_ff @(posedge clk)
	begin
		if (sys_rst || sar_start)
			cnt_q <= 4'h0;
		else if (sar_step)
			cnt_q <= cnt_q + 4'h1;
	end

	sarc_sar u_sar (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(sar_start),
		.step(sar_step),
		.comp_hi(comp_hi),
		.trial_q(trial),
		.done(sar_done)
	);

	// Latch result and flag in LOAD, busy_n rises on the same edge
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			result_bits <= `SARC_RES_RST;
			out_of_range_flag <= 1'b0;
			over_q <= 1'b0;
			under_q <= 1'b0;
		end
		else if (state_q == sarc_pkg::SARC_LOAD)
		begin
			result_bits <= flip_msb(trial);
			over_q <= (ain_code > full_pos);
			under_q <= (ain_code <= full_neg);
			out_of_range_flag <= (ain_code > full_pos) ||
				(ain_code <= full_neg);
		end
	end

	// Busy low from start until the latch cycle has passed; forced high whenever the power mode is not active
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			busy_n <= 1'b1;
		else if (pwr_q != sarc_pkg::SARC_ACTIVE)
			busy_n <= 1'b1;
		else if (sar_start)
			busy_n <= 1'b0;
		else if (state_q == sarc_pkg::SARC_LOAD)
			busy_n <= 1'b1;
	end

	// Events: done, overrange, underrange, ignored start
	assign events[`SARC_EV_DONE] = (state_q == sarc_pkg::SARC_LOAD);
	assign events[`SARC_EV_OVR] = (state_q == sarc_pkg::SARC_LOAD) &&
		(ain_code > full_pos);
	assign events[`SARC_EV_UNDR] = (state_q == sarc_pkg::SARC_LOAD) &&
		(ain_code <= full_neg);
	assign events[`SARC_EV_IGN] = start_edge && !sar_start;

	// AXI write: take address and data together, answer next cycle
	// Control is read-only: a bus start would bypass the pin edge
	logic wr_go;
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign bresp_d = (s_axi_awaddr == `SARC_ADDR_CLEAR ||
		s_axi_awaddr == `SARC_ADDR_ENABLE) ? 2'h0 : 2'h2;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= bresp_d;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Enable register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			enable_q <= 4'h0;
		else if (wr_go && s_axi_awaddr == `SARC_ADDR_ENABLE &&
			s_axi_wstrb[0])
			enable_q <= s_axi_wdata[`SARC_NEV-1:0];
	end

	// Sticky status; a new event wins over a same-cycle clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			status_q <= 4'h0;
		else if (wr_go && s_axi_awaddr == `SARC_ADDR_CLEAR &&
			s_axi_wstrb[0])
			status_q <= (status_q & ~s_axi_wdata[`SARC_NEV-1:0]) | events;
		else
			status_q <= status_q | events;
	end
	assign irq = |(status_q & enable_q);

	// AXI read: one cycle latency, SLVERR on unmapped
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			unique case (s_axi_araddr)
				`SARC_ADDR_STATUS:
					s_axi_rdata <= {28'h0000000, status_q};
				`SARC_ADDR_ENABLE:
					s_axi_rdata <= {28'h0000000, enable_q};
				`SARC_ADDR_RESULT:
					s_axi_rdata <= {16'h0000, under_q, over_q, result_bits};
				`SARC_ADDR_CTRL:
					s_axi_rdata <= {20'h00000, cnt_q, 2'h0, span_sel,
						pwr_q, ~busy_n, state_q != sarc_pkg::SARC_IDLE};
				`SARC_ADDR_CLEAR:
					s_axi_rdata <= 32'h0000_0000;
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Checks
	a_busy_low_conv: assert property (@(posedge clk) disable iff (sys_rst)
		state_q == sarc_pkg::SARC_CONV |-> !busy_n)
		else $error("busy_n high during conversion");
	a_start_fall: assert property (@(posedge clk) disable iff (sys_rst)
		sar_start |-> $past(cs_s) && !cs_s)
		else $error("conversion began without an edge");
	a_busy_start: assert property (@(posedge clk) disable iff (sys_rst)
		sar_start |=> !busy_n)
		else $error("busy_n not low after start");
	a_no_restart: assert property (@(posedge clk) disable iff (sys_rst)
		state_q == sarc_pkg::SARC_CONV |-> !sar_start)
		else $error("conversion restarted");
	a_conv_len: assert property (@(posedge clk) disable iff (sys_rst)
		sar_start |=> (state_q == sarc_pkg::SARC_CONV)[*8] ##1
		(state_q == sarc_pkg::SARC_CONV)[*7] ##1
		state_q == sarc_pkg::SARC_LOAD)
		else $error("conversion not 14 steps");
	a_result_first: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(busy_n) && pwr_q == sarc_pkg::SARC_ACTIVE |->
		$past(state_q) == sarc_pkg::SARC_LOAD)
		else $error("busy rose before result loaded");
	a_flag_range: assert property (@(posedge clk) disable iff (sys_rst)
		state_q == sarc_pkg::SARC_LOAD && ain_code <= full_pos &&
		ain_code > full_neg |=> !out_of_range_flag)
		else $error("flag set in range");
	a_over_msb: assert property (@(posedge clk) disable iff (sys_rst)
		state_q == sarc_pkg::SARC_LOAD && ain_code > full_pos |=>
		out_of_range_flag && !result_bits[13])
		else $error("overrange coding wrong");
	a_under_msb: assert property (@(posedge clk) disable iff (sys_rst)
		state_q == sarc_pkg::SARC_LOAD && ain_code <= full_neg |=>
		out_of_range_flag && result_bits[13])
		else $error("underrange coding wrong");
	a_pwr_idle: assert property (@(posedge clk) disable iff (sys_rst)
		pwr_q != sarc_pkg::SARC_ACTIVE |-> !sar_start ##1 busy_n)
		else $error("conversion in power-down");
	c_conv: cover property (@(posedge clk) sar_start ##17 $rose(busy_n));
	c_over: cover property (@(posedge clk) events[`SARC_EV_OVR]);
	c_under: cover property (@(posedge clk) events[`SARC_EV_UNDR]);
	c_ign: cover property (@(posedge clk) events[`SARC_EV_IGN]);
	c_nap: cover property (@(posedge clk) pwr_q == sarc_pkg::SARC_NAP);
endmodule

// >>> verification/sarc_host.sv
// Host model that drives the converter's start strobe.
// Assumes the converter's busy_n and nap_n pins are visible to it.
`include "sarc_defs.svh"
module sarc_host (
	// Clock and converter status
	input wire logic clk,
	input wire logic busy_n,
	input wire logic nap_n,
	// Start strobe
	output logic convert_start_n
);
	timeunit 1ns;
	timeprecision 1ns;
	int idle_q = 0;

	initial convert_start_n = 1'b1;

	// Cycles idle and awake; gates when a new start may go out
	always @(posedge clk)
		if (busy_n !== 1'b1 || nap_n !== 1'b1)
			idle_q <= 0;
		else if (idle_q < 1000)
			idle_q <= idle_q + 1;

	// Falling strobe held two cycles; now skips the idle wait
	// n above 200 tells the caller the wait ran out
	task automatic fire(input bit now, output int n);
		n = 0;
		// Margin of three covers the converter's pin sync delay
		while (!now && idle_q < `SARC_NAP_WAKE_CYC + 3 && n <= 200)
		begin
			@(posedge clk);
			n++;
		end
		convert_start_n <= 1'b0;
		repeat (2) @(posedge clk);
		convert_start_n <= 1'b1;
	endtask
endmodule

// >>> verification/test_sarc_top.sv
// Self-checking bench for the SAR conversion control.
// Assumes sarc_host drives the strobe; write strobes are tied to all ones.
`include "sarc_defs.svh"
module test_sarc_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, sys_rst, convert_start_n, range_select0, range_select1;
	logic nap_n, deep_powerdown_n, busy_n, out_of_range_flag, ref_active;
	logic [`SARC_MSB:0] result_bits;
	logic signed [15:0] ain_code;
	logic [1:0] span_sel, s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, irq;
	int errors, checks_done;

	sarc_top dut (.*);
	sarc_host h (.clk(clk), .busy_n(busy_n), .nap_n(nap_n),
		.convert_start_n(convert_start_n));

	// 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// A wait that runs out ends the run at once
	task automatic tout(input int c);
		if (c > 200)
		begin
			errors++;
			$display("wrong value wait bound exp 200 got %0d", c);
			report_and_stop();
		end
	endtask

	task automatic chk(input string s, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask

	task automatic wait_b(input logic v, output int c);
		c = 0;
		while (busy_n !== v)
		begin
			@(posedge clk);
			c++;
			tout(c);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] e);
		int c;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		c = 0;
		do
		begin
			@(posedge clk);
			c++;
			tout(c);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", e, s_axi_bresp);
		@(posedge clk);
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
		input logic [1:0] e);
		int c;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		c = 0;
		do
		begin
			@(posedge clk);
			c++;
			tout(c);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk("rresp", e, s_axi_rresp);
		@(posedge clk);
	endtask

	// Busy must stay high for a while
	task automatic quiet();
		repeat (30)
		begin
			@(posedge clk);
			chk("busy idle", 1, busy_n);
		end
	endtask

	// One conversion, judged at the first edge busy is back high
	task automatic t_conv(input logic signed [15:0] v, input logic f);
		int c;
		ain_code <= v;
		h.fire(1'b0, c);
		tout(c);
		wait_b(1'b0, c);
		wait_b(1'b1, c);
		chk("busy low span", 16, c);
		chk("range flag", f, out_of_range_flag);
		chk("result msb", v[15], result_bits[13]);
		if (!f)
			chk("result", v[13:0], result_bits);
	endtask

	task automatic t_ignore();
		int c;
		ain_code <= 16'sh0123;
		h.fire(1'b0, c);
		tout(c);
		wait_b(1'b0, c);
		h.fire(1'b1, c);
		wait_b(1'b1, c);
		chk("busy low span", 14, c);
		quiet();
		chk("result", 14'h0123, result_bits);
	endtask

	task automatic t_power();
		int c;
		nap_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk("reference in nap", 1, ref_active);
		h.fire(1'b1, c);
		quiet();
		deep_powerdown_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk("reference in sleep", 0, ref_active);
		h.fire(1'b1, c);
		quiet();
		nap_n <= 1'b1;
		deep_powerdown_n <= 1'b1;
		t_conv(16'sh0fff, 1'b0);
	endtask

	// Index is {select1, select0}; spans listed from the rule table
	task automatic t_span();
		sarc_pkg::sarc_span_t exp_span [4];
		exp_span = '{sarc_pkg::SARC_M9DB, sarc_pkg::SARC_M3DB,
			sarc_pkg::SARC_M6DB, sarc_pkg::SARC_0DB};
		for (int i = 0; i < 4; i++)
		begin
			{range_select1, range_select0} <= i[1:0];
			repeat (4) @(posedge clk);
			chk("span", exp_span[i], span_sel);
		end
	endtask

	// Sticky events, clear, enable and an unmapped address
	task automatic t_axi();
		axi_rd(`SARC_ADDR_STATUS, rd, 2'h0);
		chk("status", 4'hf, rd[3:0]);
		axi_wr(`SARC_ADDR_CLEAR, 32'hf, 2'h0);
		axi_rd(`SARC_ADDR_STATUS, rd, 2'h0);
		chk("status cleared", 0, rd[3:0]);
		axi_wr(`SARC_ADDR_ENABLE, 32'h1, 2'h0);
		chk("irq idle", 0, irq);
		t_conv(16'sh0200, 1'b0);
		chk("irq raised", 1, irq);
		axi_rd(`SARC_ADDR_RESULT, rd, 2'h0);
		chk("result register", 32'h0200, rd[15:0]);
		axi_wr(`SARC_ADDR_ENABLE, 32'h0, 2'h0);
		chk("irq masked", 0, irq);
		axi_wr(`SARC_ADDR_CLEAR, 32'h1, 2'h0);
		axi_wr(`SARC_ADDR_ENABLE, 32'h1, 2'h0);
		chk("irq cleared", 0, irq);
		axi_wr(`SARC_ADDR_CTRL, 32'h1, 2'h2);
		quiet();
		axi_rd(`SARC_ADDR_CTRL, rd, 2'h0);
		chk("ctrl word", 32'h0000_0f00, rd);
		axi_rd(32'h0000_0040, rd, 2'h2);
		axi_wr(32'h0000_0040, 32'h0, 2'h2);
	endtask

	// Main sequence
	initial
	begin
		errors = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		{range_select0, range_select1, nap_n, deep_powerdown_n} = 4'hf;
		ain_code = 16'sh0000;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("busy after reset", 1, busy_n);
		chk("result after reset", 0, result_bits);
		chk("irq after reset", 0, irq);
		t_span();
		t_conv(16'sh0000, 1'b0);
		t_conv(-16'sd1, 1'b0);
		t_conv(16'sd8191, 1'b0);
		t_conv(-16'sd8191, 1'b0);
		t_conv(16'sd9000, 1'b1);
		t_conv(-16'sd8192, 1'b1);
		t_ignore();
		t_power();
		t_axi();
		report_and_stop();
	end
endmodule
